// >>> rtl/core_idle_state_resolver.sv
// core idle state resolution, legacy port trap and power action sequencing
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module core_idle_state_resolver
	import idle_pkg::*;
#(
	parameter int THREADS = 2,
	parameter int TW = (THREADS > 1) ? $clog2(THREADS) : 1
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata_r,
	// thread monitor wait and halt requests
	input wire logic [THREADS-1:0] waitReq,
	input wire logic [THREADS-1:0][2:0] waitState,
	input wire logic [THREADS-1:0][3:0] waitHint,
	input wire logic [THREADS-1:0] waitTimed,
	input wire logic [THREADS-1:0] waitBreakIf,
	input wire logic [THREADS-1:0][15:0] waitDeadline,
	input wire logic [THREADS-1:0] haltReq,
	// legacy idle level port reads
	input wire logic ioRd,
	input wire logic [15:0] ioAddr,
	input wire logic [TW-1:0] ioThread,
	output logic ioPass_r,
	output logic ioTrap_r,
	// wake sources
	input wire logic [THREADS-1:0] irqThread,
	input wire logic [THREADS-1:0] intEnable,
	input wire logic pkgIrq,
	input wire logic [THREADS-1:0] monAccess,
	// power action handshakes
	input wire logic flushDone,
	input wire logic saveDone,
	// core state and actions
	output cstate_t coreState_r,
	output logic [THREADS-1:0] threadActive_r,
	output logic execStop_r,
	output logic clkGate_r,
	output logic lowOpPoint_r,
	output logic flushReq_r,
	output logic saveReq_r,
	output logic clkStop_r,
	output logic voltLower_r
);

	// ==========================================================
	// elaboration check
	if (THREADS < 1 || THREADS > 4) begin : bad_threads
		$error("THREADS must be 1 to 4");
	end
	if (TW < ((THREADS > 1) ? $clog2(THREADS) : 1)) begin : bad_width
		$error("TW too narrow for THREADS");
	end

	// ==========================================================
	// configuration registers
	logic [31:0] cfg_r;
	logic [31:0] trap_r;
	logic [15:0] tickCnt_r;
	logic tick_r;
	kstate_t kState_r;
	kstate_t kState_nxt;
	cstate_t coreState_nxt;
	cstate_t target;
	cstate_t resolved;
	cstate_t effState [THREADS];
	logic [31:0] statWord;
	logic [31:0] hintWord;
	logic [THREADS-1:0] ioSel;
	logic tgtLower;
	logic tgtHit;
	logic [THREADS-1:0] actNow;
	logic [3:0] hintArr [THREADS];

	wire cfgSel = regAddr == CFG_OFS;
	wire trapSel = regAddr == TRAP_OFS;
	wire statSel = regAddr == STAT_OFS;
	wire hintSel = regAddr == HINT_OFS;
	// all features except break on interrupt for redirected reads off until firmware sets them
	wire redirEn = cfg_r[CFG_REDIR_BIT];
	wire demoteEn = cfg_r[CFG_DEMOTE_BIT];
	wire mtEn = cfg_r[CFG_MT_BIT];
	wire pkgWakeEn = cfg_r[CFG_PKGWAKE_BIT];
	wire ioBrkDis = cfg_r[CFG_IOBRK_DIS_BIT];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_r <= CFG_RST;
			trap_r <= TRAP_RST;
		end else if (regWr) begin
			if (cfgSel)
				cfg_r <= regWdata;
			if (trapSel)
				trap_r <= regWdata;
		end
	end

	// ==========================================================
	// register read
	wire [31:0] rdMux = cfgSel ? cfg_r :
		trapSel ? trap_r :
		statSel ? statWord :
		hintSel ? hintWord : 32'h0000_0000;

	always_ff @(posedge sys_clk) begin
		if (srst)
			regRdata_r <= 32'h0000_0000;
		else
			regRdata_r <= regRd ? rdMux : 32'h0000_0000;
	end

	// ==========================================================
	// deadline tick divider
	wire tickWrap = tickCnt_r == TICK_CYCLES - 16'h0001;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tickCnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= tickWrap;
			tickCnt_r <= tickWrap ? 16'h0000 : tickCnt_r + 16'h0001;
		end
	end

	// ==========================================================
	// legacy port trap
	wire [15:0] trapBase = trap_r[15:0];
	wire [2:0] trapRange = trap_r[TRAP_RANGE_LSB +: 3];
	wire [15:0] lvlOfs = ioAddr - trapBase;
	// trap only inside the programmed range
	wire ioHit = redirEn && (ioAddr >= trapBase) && (lvlOfs < {13'h0000, trapRange});
	wire cstate_t ioState = lvlState(lvlOfs[1:0]);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ioPass_r <= 1'b0;
			ioTrap_r <= 1'b0;
		end else begin
			// trapped reads never leave as external reads
			ioPass_r <= ioRd && !ioHit;
			ioTrap_r <= ioRd && ioHit;
		end
	end

	// ==========================================================
	// thread slots
	thread_if tif [THREADS] ();

	for (genvar g = 0; g < THREADS; g++) begin : thr
		assign ioSel[g] = ioRd && ioHit && (ioThread == TW'(g));
		// extra threads only with multithreading on
		assign tif[g].present = (g == 0) || (mtEn && (THREADS > 1));
		assign tif[g].enter = waitReq[g] || haltReq[g] || ioSel[g];
		assign tif[g].enterState = waitReq[g] ? cstate_t'(waitState[g]) :
			haltReq[g] ? CS_C1 : ioState;
		assign tif[g].enterHint = waitReq[g] ? waitHint[g] : 4'h0;
		assign tif[g].enterTimed = waitReq[g] && waitTimed[g];
		assign tif[g].enterWait = waitReq[g] || ioSel[g];
		// break on masked interrupt by default
		assign tif[g].enterBreak = waitReq[g] ? waitBreakIf[g] : (ioSel[g] && !ioBrkDis);
		assign tif[g].enterDeadline = waitDeadline[g];
		assign tif[g].irq = irqThread[g];
		assign tif[g].intEn = intEnable[g];
		assign tif[g].pkgWake = pkgIrq && pkgWakeEn;
		assign tif[g].monHit = monAccess[g];
		assign tif[g].tick = tick_r;
		assign effState[g] = tif[g].present ? tif[g].state : CS_C10;
		assign actNow[g] = tif[g].present && (tif[g].state == CS_C0);
		assign hintArr[g] = tif[g].hint;

		idle_thread_slot u_slot (
			.sys_clk(sys_clk),
			.srst(srst),
			.port(tif[g].slot)
		);
	end

	// ==========================================================
	// resolution
	// lowest numerical thread state, falls out at C0
	always_comb begin
		resolved = CS_C10;
		for (int t = 0; t < THREADS; t++)
			resolved = minState(resolved, effState[t]);
	end

	assign target = (demoteEn && (resolved > CS_C1E)) ? CS_C1E : resolved;

	always_comb begin
		statWord = 32'h0000_0000;
		hintWord = 32'h0000_0000;
		statWord[2:0] = coreState_r;
		for (int t = 0; t < THREADS; t++) begin
			statWord[STAT_ACT_LSB + t] = threadActive_r[t];
			statWord[STAT_THR_LSB + 4 * t +: 3] = effState[t];
			hintWord[4 * t +: 4] = hintArr[t];
		end
	end

	// ==========================================================
	// core action sequencer
	always_comb begin
		kState_nxt = kState_r;
		coreState_nxt = coreState_r;
		case (kState_r)
			K_ACTIVE: begin
				if (target != CS_C0) begin
					coreState_nxt = target;
					kState_nxt = (target <= CS_C1E) ? K_SHALLOW : K_FLUSH;
				end
			end
			default: begin
				if (target == CS_C0 || target != coreState_r) begin
					// any change of idle state passes C0
					coreState_nxt = CS_C0;
					kState_nxt = K_ACTIVE;
				end else if (kState_r == K_FLUSH && flushDone) begin
					kState_nxt = K_SAVE;
				end else if (kState_r == K_SAVE && saveDone) begin
					kState_nxt = K_CLKOFF;
				end else if (kState_r == K_CLKOFF) begin
					kState_nxt = K_VOLT;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			kState_r <= K_ACTIVE;
			coreState_r <= CS_C0;
		end else begin
			kState_r <= kState_nxt;
			coreState_r <= coreState_nxt;
		end
	end

	// actions from next sequencer and core state, thread active flags from thread states
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			execStop_r <= 1'b0;
			clkGate_r <= 1'b0;
			lowOpPoint_r <= 1'b0;
			flushReq_r <= 1'b0;
			saveReq_r <= 1'b0;
			clkStop_r <= 1'b0;
			voltLower_r <= 1'b0;
			threadActive_r <= '0;
		end else begin
			execStop_r <= kState_nxt != K_ACTIVE;
			clkGate_r <= kState_nxt == K_SHALLOW;
			lowOpPoint_r <= (kState_nxt == K_SHALLOW) && (coreState_nxt == CS_C1E);
			flushReq_r <= kState_nxt == K_FLUSH;
			saveReq_r <= kState_nxt == K_SAVE;
			clkStop_r <= (kState_nxt == K_CLKOFF) || (kState_nxt == K_VOLT);
			voltLower_r <= kState_nxt == K_VOLT;
			threadActive_r <= actNow;
		end
	end

	// ==========================================================
	// checks
	always_comb begin
		tgtLower = 1'b0;
		tgtHit = 1'b0;
		for (int t = 0; t < THREADS; t++) begin
			tgtLower = tgtLower || (effState[t] < coreState_r);
			tgtHit = tgtHit || (effState[t] == coreState_r);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	resolve_lowest_a: assert property ((kState_r != K_ACTIVE && !demoteEn
		&& target == $past(target)) |-> !tgtLower && tgtHit)
		else $error("core state is not the lowest thread state");
	wake_to_c0_a: assert property (target == CS_C0 |=> coreState_r == CS_C0)
		else $error("core did not return to C0");
	via_c0_a: assert property ((coreState_r != CS_C0 && $past(coreState_r) != CS_C0)
		|-> coreState_r == $past(coreState_r))
		else $error("idle change skipped C0");
	shallow_gate_a: assert property (clkGate_r
		|-> execStop_r && (coreState_r == CS_C1 || coreState_r == CS_C1E))
		else $error("clock gating outside C1 or C1E");
	low_point_a: assert property (lowOpPoint_r |-> coreState_r == CS_C1E)
		else $error("low operating point outside C1E");
	flush_core_a: assert property (flushReq_r |-> coreState_r >= CS_C6)
		else $error("flush without resolved deep state");
	deep_order_a: assert property (($rose(saveReq_r) |-> $past(flushReq_r))
		and ($rose(clkStop_r) |-> $past(saveReq_r)) and (voltLower_r |-> clkStop_r))
		else $error("deep state actions out of order");
	io_trap_a: assert property ((ioRd && ioHit) |=> ioTrap_r && !ioPass_r)
		else $error("trapped read left as external read");
	io_pass_a: assert property ((ioRd && !ioHit) |=> ioPass_r && !ioTrap_r)
		else $error("out of range read was trapped");
	reset_init_a: assert property (disable iff (1'b0) srst |=>
		coreState_r == CS_C0 && !execStop_r && kState_r == K_ACTIVE)
		else $error("reset did not reinitialise core");

	// ==========================================================
	// wake and action checks
	active_c0_a: assert property ((|actNow) |=> coreState_r == CS_C0)
		else $error("active thread did not hold core in C0");
	single_wake_a: assert property ((tif[0].state != CS_C0 && !irqThread[0]
		&& !(pkgIrq && pkgWakeEn) && !monAccess[0] && !tick_r) |=> tif[0].state != CS_C0)
		else $error("thread 0 woke without its own wake event");
	pkg_wake_a: assert property ((pkgIrq && pkgWakeEn && !waitReq[0] && !haltReq[0]
		&& !ioSel[0]) |=> tif[0].state == CS_C0)
		else $error("package interrupt did not wake thread 0");
	hint_zero_a: assert property ((ioSel[0] && !waitReq[0] && tif[0].state == CS_C0)
		|=> tif[0].hint == 4'h0)
		else $error("redirected read kept a nonzero hint");
	exec_idle_a: assert property (execStop_r |-> coreState_r != CS_C0)
		else $error("execution stopped with core in C0");
	demote_cap_a: assert property ((demoteEn && $past(demoteEn))
		|-> coreState_r <= CS_C1E)
		else $error("demotion let the core below C1E");
	volt_deep_a: assert property (voltLower_r |-> coreState_r >= CS_C6)
		else $error("voltage lowered outside a deep state");

	deep_volt_c: cover property (voltLower_r);
	transit_c: cover property (coreState_r == CS_C1E ##1 coreState_r == CS_C0 ##1
		coreState_r == CS_C6);
	io_redirect_c: cover property (ioTrap_r ##1 coreState_r != CS_C0);
	demote_c: cover property (demoteEn && resolved > CS_C1E && coreState_r == CS_C1E);

endmodule : core_idle_state_resolver

// >>> rtl/idle_thread_slot.sv
// one thread's idle state, wake conditions and deadline count
`timescale 1ns/1ps
module idle_thread_slot
	import idle_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// thread carrier
	thread_if.slot port
);

	cstate_t state_r;
	logic [3:0] hint_r;
	logic [15:0] deadline_r;
	logic timed_r;
	logic wait_r;
	logic breakIf_r;

	// ==========================================================
	// wake decode
	wire idle = state_r != CS_C0;
	wire irqWake = port.irq && (port.intEn || breakIf_r);
	wire monWake = port.monHit && wait_r;
	wire timeWake = timed_r && port.tick && (deadline_r == 16'h0000);
	wire wake = idle && (irqWake || port.pkgWake || monWake || timeWake);
	wire take = !idle && port.enter && (port.enterState != CS_C0);

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk) begin
		if (srst || !port.present) begin
			state_r <= CS_C0;
			hint_r <= 4'h0;
			deadline_r <= 16'h0000;
			timed_r <= 1'b0;
			wait_r <= 1'b0;
			breakIf_r <= 1'b0;
		end else if (wake) begin
			state_r <= CS_C0;
			timed_r <= 1'b0;
			wait_r <= 1'b0;
		end else if (take) begin
			state_r <= port.enterState;
			hint_r <= port.enterHint;
			deadline_r <= port.enterDeadline;
			timed_r <= port.enterTimed;
			wait_r <= port.enterWait;
			breakIf_r <= port.enterBreak;
		end else if (idle && timed_r && port.tick) begin
			deadline_r <= deadline_r - 16'h0001;
		end
	end

	assign port.state = state_r;
	assign port.hint = hint_r;

	// ==========================================================
	// checks
	mon_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
		(idle && monWake && port.present) |=> state_r == CS_C0)
		else $error("monitored access did not wake thread");
	deadline_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
		(idle && timeWake && port.present) |=> state_r == CS_C0)
		else $error("deadline expiry did not wake thread");
	masked_irq_a: assert property (@(posedge sys_clk) disable iff (srst)
		(idle && breakIf_r && port.irq && port.present) |=> state_r == CS_C0)
		else $error("break on interrupt did not wake thread");
	deadline_hit_c: cover property (@(posedge sys_clk) disable iff (srst) idle && timeWake);

endmodule : idle_thread_slot

// >>> shared/idle_pkg.sv
// constants, types and helpers for the core idle state resolver
// ==========================================================
package idle_pkg;

	typedef enum logic [2:0] {CS_C0, CS_C1, CS_C1E, CS_C6, CS_C8, CS_C10} cstate_t;
	typedef enum logic [2:0] {K_ACTIVE, K_SHALLOW, K_FLUSH, K_SAVE, K_CLKOFF, K_VOLT} kstate_t;

	// ==========================================================
	// register map
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] TRAP_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] HINT_OFS = 8'h0C;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] TRAP_RST = 32'h0000_0000;
	localparam int CFG_REDIR_BIT = 0;
	localparam int CFG_DEMOTE_BIT = 1;
	localparam int CFG_MT_BIT = 2;
	localparam int CFG_PKGWAKE_BIT = 3;
	localparam int CFG_IOBRK_DIS_BIT = 4;
	localparam int TRAP_RANGE_LSB = 16;
	localparam int STAT_ACT_LSB = 8;
	localparam int STAT_THR_LSB = 16;

	// ==========================================================
	// deadline tick
	localparam int CLK_NS = 5;
	localparam int TICK_NS = 1000;
	localparam logic [15:0] TICK_CYCLES = 16'((TICK_NS + CLK_NS - 1) / CLK_NS);

	function automatic cstate_t minState(input cstate_t a, input cstate_t b);
		return (a < b) ? a : b;
	endfunction : minState

	function automatic cstate_t lvlState(input logic [1:0] idx);
		case (idx)
			2'h0: return CS_C1;
			2'h1: return CS_C6;
			2'h2: return CS_C8;
			default: return CS_C10;
		endcase
	endfunction : lvlState

endpackage : idle_pkg

// >>> shared/thread_if.sv
// per-thread request and state carrier between resolver and thread slot
`timescale 1ns/1ps
interface thread_if;
	import idle_pkg::*;
	logic present;
	logic enter;
	cstate_t enterState;
	logic [3:0] enterHint;
	logic enterTimed;
	logic enterWait;
	logic enterBreak;
	logic [15:0] enterDeadline;
	logic irq;
	logic intEn;
	logic pkgWake;
	logic monHit;
	logic tick;
	cstate_t state;
	logic [3:0] hint;
	modport core(output present, enter, enterState, enterHint, enterTimed, enterWait,
		enterBreak, enterDeadline, irq, intEn, pkgWake, monHit, tick, input state, hint);
	modport slot(input present, enter, enterState, enterHint, enterTimed, enterWait,
		enterBreak, enterDeadline, irq, intEn, pkgWake, monHit, tick, output state, hint);
endinterface : thread_if

// >>> verif/tb.sv
// self-checking testbench of the core idle state resolver
`timescale 1ns/1ps
module tb;
	import idle_pkg::*;
	// ==========================================================
	// signals
	logic sys_clk, srst, regWr, regRd, ioRd, ioPass_r, ioTrap_r, pkgIrq, flushDone, saveDone;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata_r, rd;
	logic [15:0] ioAddr, ioA;
	logic [0:0] ioThread;
	logic [1:0] waitReq, waitTimed, waitBreakIf, haltReq, irqThread, intEnable, monAccess;
	logic [1:0][2:0] waitState;
	logic [1:0][3:0] waitHint;
	logic [1:0][15:0] waitDeadline;
	logic [1:0] threadActive_r;
	cstate_t coreState_r, prevCore;
	logic execStop_r, clkGate_r, lowOpPoint_r, flushReq_r, saveReq_r, clkStop_r, voltLower_r;
	logic [2:0] s0, s1;
	int fails, checked, seed;

	// ==========================================================
	// instances
	core_idle_state_resolver #(.THREADS(2)) u_core_idle_state_resolver (.sys_clk, .srst,
		.regAddr, .regWdata, .regWr, .regRd, .regRdata_r, .waitReq, .waitState, .waitHint,
		.waitTimed, .waitBreakIf, .waitDeadline, .haltReq, .ioRd, .ioAddr, .ioThread,
		.ioPass_r, .ioTrap_r, .irqThread, .intEnable, .pkgIrq, .monAccess, .flushDone,
		.saveDone, .coreState_r, .threadActive_r, .execStop_r, .clkGate_r, .lowOpPoint_r,
		.flushReq_r, .saveReq_r, .clkStop_r, .voltLower_r);
	thread_model u_thread_model (.sys_clk, .waitReq, .waitState, .waitHint, .waitTimed,
		.waitBreakIf, .waitDeadline, .haltReq, .irqThread, .intEnable, .pkgIrq, .monAccess);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// helpers
	task automatic end_sim();
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 d = regRdata_r;
	endtask : rdr

	task automatic io(input logic [15:0] a, input logic t, input logic [1:0] e);
		@(posedge sys_clk);
		ioRd <= 1'b1;
		ioAddr <= a;
		ioThread <= t;
		@(posedge sys_clk);
		ioRd <= 1'b0;
		#1 chk({ioPass_r, ioTrap_r}, e);
	endtask : io

	task automatic pulse(input int sel);
		@(posedge sys_clk);
		if (sel == 0) flushDone <= 1'b1;
		else saveDone <= 1'b1;
		@(posedge sys_clk);
		{flushDone, saveDone} <= 2'b00;
	endtask : pulse

	function automatic logic pick(input int sel);
		case (sel)
			0: return flushReq_r;
			1: return saveReq_r;
			2: return clkStop_r;
			default: return threadActive_r[0];
		endcase
	endfunction : pick

	task automatic waitHi(input int sel, input int n);
		#1;
		for (int i = 0; i < n && pick(sel) !== 1'b1; i++) @(posedge sys_clk) #1;
		chk(pick(sel), 1);
		if (pick(sel) !== 1'b1) end_sim();
	endtask : waitHi

	task automatic waitCore(input logic [2:0] e);
		#1;
		for (int i = 0; i < 30 && coreState_r !== e; i++) @(posedge sys_clk) #1;
		chk(coreState_r, e);
		if (coreState_r !== e) end_sim();
	endtask : waitCore

	function automatic logic [2:0] expMin(input logic [2:0] a, input logic [2:0] b);
		return (a < b) ? a : b;
	endfunction : expMin

	// trap window is base 0x0400, four levels, redirect enabled
	function automatic logic [1:0] expIo(input logic [15:0] a);
		return (a >= 16'h0400 && a < 16'h0404) ? 2'b01 : 2'b10;
	endfunction : expIo

	task automatic wakeAll();
		u_thread_model.pkg(2);
		waitCore(CS_C0);
		repeat (2) @(posedge sys_clk);
		#1 chk(threadActive_r, 2'b11);
	endtask : wakeAll

	always @(posedge sys_clk) begin
		if (!srst && prevCore !== CS_C0 && coreState_r !== CS_C0 && coreState_r !== prevCore)
			chk(coreState_r, CS_C0);
		prevCore <= coreState_r;
	end

	initial begin
		#400000;
		fails++;
		$display("unexpected at %0t: run limit reached", $time);
		end_sim();
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 65;
		fails = 0;
		checked = 0;
		srst = 1'b1;
		{regWr, regRd, ioRd, flushDone, saveDone} = '0;
		regAddr = '0;
		regWdata = '0;
		ioAddr = '0;
		ioThread = '0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1 chk(coreState_r, CS_C0);
		chk(threadActive_r, 2'b01);
		rdr(CFG_OFS, rd);
		chk(rd, CFG_RST);
		rdr(8'h10, rd);
		chk(rd, 32'h0000_0000);
		u_thread_model.halt(0);
		waitCore(CS_C1);
		chk({execStop_r, clkGate_r, lowOpPoint_r}, 3'b110);
		u_thread_model.irq(0, 2);
		waitCore(CS_C0);
		wr(CFG_OFS, 32'h0000_000D);
		repeat (2) @(posedge sys_clk);
		#1 chk(threadActive_r, 2'b11);
		u_thread_model.req(0, CS_C1E, 4'hF, 16'h0000);
		repeat (4) @(posedge sys_clk);
		#1 chk(coreState_r, CS_C0);
		chk({execStop_r, clkGate_r}, 2'b00);
		u_thread_model.req(1, CS_C6, 4'h0, 16'h0000);
		waitCore(CS_C1E);
		chk({execStop_r, clkGate_r, lowOpPoint_r}, 3'b111);
		u_thread_model.irq(1, 2);
		waitCore(CS_C0);
		chk(threadActive_r, 2'b10);
		u_thread_model.req(1, CS_C1, 4'h0, 16'h0000);
		u_thread_model.mon(0);
		repeat (3) @(posedge sys_clk);
		#1 chk(threadActive_r, 2'b01);
		u_thread_model.irq(1, 2);
		u_thread_model.req(1, CS_C6, 4'h0, 16'h0000);
		u_thread_model.req(0, CS_C8, 4'h0, 16'h0002);
		waitCore(CS_C6);
		repeat (350) @(posedge sys_clk);
		#1 chk(threadActive_r, 2'b00);
		waitHi(3, 400);
		u_thread_model.irq(1, 2);
		wr(CFG_OFS, 32'h0000_000F);
		u_thread_model.req(0, CS_C6, 4'h5, 16'h0000);
		u_thread_model.req(1, CS_C6, 4'h0, 16'h0000);
		waitCore(CS_C1E);
		wr(CFG_OFS, 32'h0000_000D);
		waitCore(CS_C6);
		waitHi(0, 10);
		repeat (3) @(posedge sys_clk);
		#1 chk({saveReq_r, clkStop_r}, 2'b00);
		pulse(0);
		waitHi(1, 10);
		chk(clkStop_r, 0);
		pulse(1);
		waitHi(2, 10);
		chk(voltLower_r, 0);
		@(posedge sys_clk);
		#1 chk(voltLower_r, 1);
		wakeAll();
		wr(TRAP_OFS, 32'h0004_0400);
		io(16'h0401, 1'b0, 2'b01);
		rdr(STAT_OFS, rd);
		chk(rd[18:16], CS_C6);
		rdr(HINT_OFS, rd);
		chk(rd[3:0], 4'h0);
		io(16'h0404, 1'b1, 2'b10);
		u_thread_model.setIe(2'b10);
		u_thread_model.irq(0, 2);
		waitHi(3, 10);
		u_thread_model.setIe(2'b11);
		repeat (6) begin
			s0 = 3'(1 + {$random(seed)} % 5);
			s1 = 3'(1 + {$random(seed)} % 5);
			u_thread_model.req(0, s0, 4'($random(seed)), 16'h0000, 1'($random(seed)));
			u_thread_model.req(1, s1, 4'($random(seed)), 16'h0000, 1'($random(seed)));
			waitCore(expMin(s0, s1));
			ioA = 16'h03FC + 16'({$random(seed)} % 12);
			io(ioA, 1'($random(seed)), expIo(ioA));
			u_thread_model.mon(1);
			waitCore(CS_C0);
			wakeAll();
		end
		u_thread_model.halt(0);
		u_thread_model.halt(1);
		waitCore(CS_C1);
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		#1 chk(coreState_r, CS_C0);
		chk({execStop_r, clkGate_r, lowOpPoint_r, flushReq_r, clkStop_r}, 5'h00);
		rdr(CFG_OFS, rd);
		chk(rd, CFG_RST);
		end_sim();
	end
endmodule : tb

// >>> verif/thread_model.sv
// partner model of the software threads and interrupt delivery
`timescale 1ns/1ps
module thread_model (
	// clock
	input wire logic sys_clk,
	// thread requests
	output logic [1:0] waitReq,
	output logic [1:0][2:0] waitState,
	output logic [1:0][3:0] waitHint,
	output logic [1:0] waitTimed,
	output logic [1:0] waitBreakIf,
	output logic [1:0][15:0] waitDeadline,
	output logic [1:0] haltReq,
	// interrupts and monitor
	output logic [1:0] irqThread,
	output logic [1:0] intEnable,
	output logic pkgIrq,
	output logic [1:0] monAccess
);
	// ==========================================================
	// idle lines
	initial begin
		{waitReq, haltReq, irqThread, pkgIrq, monAccess, waitTimed, waitBreakIf} = '0;
		waitState = '0;
		waitHint = '0;
		waitDeadline = '0;
		intEnable = 2'b11;
	end

	// ==========================================================
	// requests
	task automatic req(input int t, input logic [2:0] st, input logic [3:0] h,
		input logic [15:0] dl, input logic bk = 1'b0);
		@(posedge sys_clk);
		waitReq[t] <= 1'b1;
		waitState[t] <= st;
		waitHint[t] <= h;
		waitTimed[t] <= (dl != 16'h0000);
		waitDeadline[t] <= dl;
		waitBreakIf[t] <= bk;
		@(posedge sys_clk);
		// released lines show the inverse of the last value
		waitReq[t] <= 1'b0;
		waitBreakIf[t] <= ~bk;
		waitState[t] <= ~st;
		waitHint[t] <= ~h;
		waitTimed[t] <= (dl == 16'h0000);
		waitDeadline[t] <= ~dl;
	endtask : req

	task automatic halt(input int t);
		@(posedge sys_clk);
		haltReq[t] <= 1'b1;
		@(posedge sys_clk);
		haltReq[t] <= 1'b0;
	endtask : halt

	task automatic irq(input int t, input int n);
		@(posedge sys_clk);
		irqThread[t] <= 1'b1;
		repeat (n) @(posedge sys_clk);
		irqThread[t] <= 1'b0;
	endtask : irq

	task automatic pkg(input int n);
		@(posedge sys_clk);
		pkgIrq <= 1'b1;
		repeat (n) @(posedge sys_clk);
		pkgIrq <= 1'b0;
	endtask : pkg

	task automatic mon(input int t);
		@(posedge sys_clk);
		monAccess[t] <= 1'b1;
		@(posedge sys_clk);
		monAccess[t] <= 1'b0;
	endtask : mon

	task automatic setIe(input logic [1:0] v);
		@(posedge sys_clk);
		intEnable <= v;
	endtask : setIe
endmodule : thread_model
